// ==== rtl/tgm_pkg.sv ====
// Contract
// - Soft reset restores all registers; bit reads zero
// - Outputs dc inactive until gate, then next vertical edge
// - Input enable one: pin input; zero: output
// - Source select: clamp, pre-blank, general bit, shutter
// - Polarity sets active level; suspend halts clocks
// - Core reset bit zero holds core reset
// - Oscillator reset bit zero keeps oscillator down
// - Update line selects frame-update transfer line
// - Freeze bit blocks frame-updated register transfers
// - General bit applies at next vertical edge
package tgm_pkg;
    localparam logic [7:0] IDX_SOFT_RESET = 8'h10;
    localparam logic [7:0] IDX_OUTPUT_GATE = 8'h11;
    localparam logic [7:0] IDX_ALIGN_CFG = 8'h12;
    localparam logic [7:0] IDX_ALIGN_POL = 8'h13;
    localparam logic [7:0] IDX_ALIGN_SUSPEND = 8'h14;
    localparam logic [7:0] IDX_CORE_RESET_N = 8'h15;
    localparam logic [7:0] IDX_OSC_RESET = 8'h16;
    localparam logic [7:0] IDX_FACTORY_TEST = 8'h17;
    localparam logic [7:0] IDX_UPDATE_LINE = 8'h18;
    localparam logic [7:0] IDX_UPDATE_FREEZE = 8'h19;
    localparam logic [7:0] IDX_GENERAL_OUT = 8'h1A;

    localparam int ALIGN_EN_BIT = 0;
    localparam int ALIGN_SEL_LSB = 8;
    localparam int ALIGN_SEL_MSB = 9;
    localparam int ALIGN_CFG_W = 10;
    localparam int FACTORY_TEST_W = 9;
    localparam int LINE_W = 12;

    localparam logic [9:0] RST_ALIGN_CFG = 10'h001;
    localparam logic [8:0] RST_FACTORY_TEST = 9'h000;
    localparam logic [11:0] RST_UPDATE_LINE = 12'h000;

    localparam logic [1:0] SEL_BLACK_CLAMP = 2'h0;
    localparam logic [1:0] SEL_PRE_BLANK = 2'h1;
    localparam logic [1:0] SEL_GENERAL_OUT = 2'h2;
    localparam logic [1:0] SEL_SHUTTER_TEST = 2'h3;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    typedef struct packed {
        logic vertical_drive_pulse;
        logic horizontal_drive_pulse;
        logic black_clamp_pulse;
        logic pre_blank_pulse;
        logic shutter_test_output;
    } tgm_pulses_t;

    typedef struct packed {
        logic output_gate_bit;
        logic [9:0] align_cfg;
        logic align_polarity_bit;
        logic align_clock_suspend_bit;
        logic timing_core_reset_n;
        logic oscillator_reset_bit;
        logic [8:0] factory_test;
        logic [11:0] update_line;
        logic update_freeze_bit;
        logic general_output_bit;
    } tgm_regs_t;

    typedef struct packed {
        logic outputs_enable;
        logic align_pin_o;
        logic align_pin_oe;
        logic align_pulse_active;
        logic clock_suspend;
        logic core_reset_n;
        logic oscillator_enable;
        logic frame_update_strobe;
        logic soft_reset_pulse;
    } tgm_ctrl_t;

    localparam tgm_regs_t REGS_DEFAULT = '{
        output_gate_bit: 1'b0,
        align_cfg: RST_ALIGN_CFG,
        align_polarity_bit: 1'b0,
        align_clock_suspend_bit: 1'b0,
        timing_core_reset_n: 1'b0,
        oscillator_reset_bit: 1'b0,
        factory_test: RST_FACTORY_TEST,
        update_line: RST_UPDATE_LINE,
        update_freeze_bit: 1'b0,
        general_output_bit: 1'b0
    };
endpackage : tgm_pkg

// ==== rtl/tgm_pin_sync.sv ====
`timescale 1ns/10ps
module tgm_pin_sync
    import tgm_pkg::*;
#(
    parameter logic RESET_LEVEL = 1'b0
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic pin_in,
    output logic level
);
    logic s1_q, s2_q, s3_q, level_q;
    logic level_d;

    // Level moves only once stages two and three agree
    always_comb
    begin
        level_d = level_q;
        if (s2_q == s3_q)
        begin
            level_d = s3_q;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s1_q <= RESET_LEVEL;
            s2_q <= RESET_LEVEL;
            s3_q <= RESET_LEVEL;
            level_q <= RESET_LEVEL;
        end
        else
        begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            level_q <= level_d;
        end
    end

    assign level = level_q;
endmodule : tgm_pin_sync

// ==== rtl/tgm_misc_regs.sv ====
`timescale 1ns/10ps
module tgm_misc_regs
    import tgm_pkg::*;
#(
    parameter int ADDR_W = 8
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire tgm_pulses_t pulses,
    input wire logic align_pin_i,
    output tgm_ctrl_t ctrl
);
    tgm_regs_t regs_q, regs_d;
    tgm_ctrl_t ctrl_q, ctrl_d;
    logic aw_have_q, aw_have_d, w_have_q, w_have_d;
    logic [ADDR_W-1:0] aw_addr_q, aw_addr_d;
    logic [31:0] w_data_q, w_data_d;
    logic [3:0] w_strb_q, w_strb_d;
    logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d;
    logic gate_live_q, gate_live_d, gpo_live_q, gpo_live_d;
    logic [11:0] line_live_q, line_live_d, line_cnt_q, line_cnt_d;
    logic vd_prev_q, hd_prev_q;
    logic vd_rise, hd_rise, wr_fire, align_level, align_active;
    logic [7:0] wr_idx, rd_idx;
    logic [31:0] wr_old, wr_new;
    logic [3:0] sources;

    tgm_pin_sync #(
        .RESET_LEVEL(1'b0)
    ) u_align_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin_in(align_pin_i),
        .level(align_level)
    );

    function automatic logic [31:0] reg_word(input tgm_regs_t r, input logic [7:0] idx);
        logic [31:0] v;
        v = 32'h0000_0000;
        case (idx)
            IDX_OUTPUT_GATE: v[0] = r.output_gate_bit;
            IDX_ALIGN_CFG: v[ALIGN_CFG_W-1:0] = r.align_cfg;
            IDX_ALIGN_POL: v[0] = r.align_polarity_bit;
            IDX_ALIGN_SUSPEND: v[0] = r.align_clock_suspend_bit;
            IDX_CORE_RESET_N: v[0] = r.timing_core_reset_n;
            IDX_OSC_RESET: v[0] = r.oscillator_reset_bit;
            IDX_FACTORY_TEST: v[FACTORY_TEST_W-1:0] = r.factory_test;
            IDX_UPDATE_LINE: v[LINE_W-1:0] = r.update_line;
            IDX_UPDATE_FREEZE: v[0] = r.update_freeze_bit;
            IDX_GENERAL_OUT: v[0] = r.general_output_bit;
            default: v = 32'h0000_0000;
        endcase
        return v;
    endfunction : reg_word

    function automatic logic mapped(input logic [7:0] idx);
        return idx >= IDX_SOFT_RESET && idx <= IDX_GENERAL_OUT;
    endfunction : mapped

    assign vd_rise = pulses.vertical_drive_pulse && !vd_prev_q;
    assign hd_rise = pulses.horizontal_drive_pulse && !hd_prev_q;
    assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
    assign wr_idx = 8'(aw_addr_q >> 2);
    assign rd_idx = 8'(s_axi_araddr >> 2);
    assign wr_old = reg_word(regs_q, wr_idx);
    assign align_active = (align_level == regs_q.align_polarity_bit);
    assign sources = {pulses.shutter_test_output, gpo_live_q, pulses.pre_blank_pulse,
                      pulses.black_clamp_pulse};

    // Byte-lane merge over the current contents
    always_comb
    begin
        for (int b = 0; b < 4; b++)
        begin
            wr_new[b*8 +: 8] = w_strb_q[b] ? w_data_q[b*8 +: 8] : wr_old[b*8 +: 8];
        end
    end

    // Bus channels
    always_comb
    begin
        aw_have_d = aw_have_q;
        aw_addr_d = aw_addr_q;
        w_have_d = w_have_q;
        w_data_d = w_data_q;
        w_strb_d = w_strb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        rvalid_d = rvalid_q;
        rresp_d = rresp_q;
        rdata_d = rdata_q;
        if (s_axi_awvalid && s_axi_awready)
        begin
            aw_have_d = 1'b1;
            aw_addr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            w_have_d = 1'b1;
            w_data_d = s_axi_wdata;
            w_strb_d = s_axi_wstrb;
        end
        if (wr_fire)
        begin
            aw_have_d = 1'b0;
            w_have_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = mapped(wr_idx) ? RESP_OKAY : RESP_DECERR;
        end
        else if (bvalid_q && s_axi_bready)
        begin
            bvalid_d = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_d = 1'b1;
            rdata_d = reg_word(regs_q, rd_idx);
            rresp_d = mapped(rd_idx) ? RESP_OKAY : RESP_DECERR;
        end
        else if (rvalid_q && s_axi_rready)
        begin
            rvalid_d = 1'b0;
        end
    end

    // Register file and frame-timed state
    always_comb
    begin
        regs_d = regs_q;
        gate_live_d = gate_live_q;
        gpo_live_d = gpo_live_q;
        line_live_d = line_live_q;
        line_cnt_d = line_cnt_q;
        if (vd_rise)
        begin
            line_cnt_d = 12'h000;
        end
        else if (hd_rise)
        begin
            line_cnt_d = line_cnt_q + 12'h001;
        end
        if (!regs_q.update_freeze_bit)
        begin
            if (vd_rise)
            begin
                gate_live_d = regs_q.output_gate_bit;
                gpo_live_d = regs_q.general_output_bit;
            end
            if (hd_rise && line_cnt_q == line_live_q)
            begin
                line_live_d = regs_q.update_line;
            end
        end
        if (wr_fire)
        begin
            // Serial-clock fields apply now; frame fields are staged above
            case (wr_idx)
                IDX_OUTPUT_GATE: regs_d.output_gate_bit = wr_new[0];
                IDX_ALIGN_CFG: regs_d.align_cfg = wr_new[ALIGN_CFG_W-1:0];
                IDX_ALIGN_POL: regs_d.align_polarity_bit = wr_new[0];
                IDX_ALIGN_SUSPEND: regs_d.align_clock_suspend_bit = wr_new[0];
                IDX_CORE_RESET_N: regs_d.timing_core_reset_n = wr_new[0];
                IDX_OSC_RESET: regs_d.oscillator_reset_bit = wr_new[0];
                IDX_FACTORY_TEST: regs_d.factory_test = wr_new[FACTORY_TEST_W-1:0];
                IDX_UPDATE_LINE: regs_d.update_line = wr_new[LINE_W-1:0];
                IDX_UPDATE_FREEZE: regs_d.update_freeze_bit = wr_new[0];
                IDX_GENERAL_OUT: regs_d.general_output_bit = wr_new[0];
                default: regs_d = regs_q;
            endcase
        end
        if (ctrl_q.soft_reset_pulse)
        begin
            regs_d = REGS_DEFAULT;
            gate_live_d = 1'b0;
            gpo_live_d = 1'b0;
            line_live_d = RST_UPDATE_LINE;
        end
    end

    // Registered control outputs
    always_comb
    begin
        ctrl_d = '0;
        ctrl_d.soft_reset_pulse = wr_fire && wr_idx == IDX_SOFT_RESET && wr_new[0];
        ctrl_d.outputs_enable = gate_live_q;
        ctrl_d.align_pin_oe = !regs_q.align_cfg[ALIGN_EN_BIT];
        ctrl_d.align_pin_o = gate_live_q && !regs_q.align_cfg[ALIGN_EN_BIT]
                             && sources[regs_q.align_cfg[ALIGN_SEL_MSB:ALIGN_SEL_LSB]];
        ctrl_d.align_pulse_active = regs_q.align_cfg[ALIGN_EN_BIT] && align_active;
        ctrl_d.clock_suspend = regs_q.align_cfg[ALIGN_EN_BIT] && align_active
                               && regs_q.align_clock_suspend_bit;
        ctrl_d.core_reset_n = regs_q.timing_core_reset_n;
        ctrl_d.oscillator_enable = regs_q.oscillator_reset_bit;
        ctrl_d.frame_update_strobe = hd_rise && line_cnt_q == line_live_q
                                     && !regs_q.update_freeze_bit;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            regs_q <= REGS_DEFAULT;
            ctrl_q <= '0;
            aw_have_q <= 1'b0;
            aw_addr_q <= '0;
            w_have_q <= 1'b0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            rvalid_q <= 1'b0;
            rresp_q <= RESP_OKAY;
            rdata_q <= 32'h0000_0000;
            gate_live_q <= 1'b0;
            gpo_live_q <= 1'b0;
            line_live_q <= RST_UPDATE_LINE;
            line_cnt_q <= 12'h000;
            vd_prev_q <= 1'b0;
            hd_prev_q <= 1'b0;
        end
        else
        begin
            regs_q <= regs_d;
            ctrl_q <= ctrl_d;
            aw_have_q <= aw_have_d;
            aw_addr_q <= aw_addr_d;
            w_have_q <= w_have_d;
            w_data_q <= w_data_d;
            w_strb_q <= w_strb_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rvalid_q <= rvalid_d;
            rresp_q <= rresp_d;
            rdata_q <= rdata_d;
            gate_live_q <= gate_live_d;
            gpo_live_q <= gpo_live_d;
            line_live_q <= line_live_d;
            line_cnt_q <= line_cnt_d;
            vd_prev_q <= pulses.vertical_drive_pulse;
            hd_prev_q <= pulses.horizontal_drive_pulse;
        end
    end

    assign s_axi_awready = !aw_have_q && !bvalid_q;
    assign s_axi_wready = !w_have_q && !bvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;
    assign ctrl = ctrl_q;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence soft_write_s;
        wr_fire && wr_idx == IDX_SOFT_RESET && wr_new[0];
    endsequence
    sequence defaults_back_s;
        ctrl_q.soft_reset_pulse ##1 (regs_q == REGS_DEFAULT && !gate_live_q);
    endsequence

    a_soft_reset_restore: assert property (soft_write_s |=> defaults_back_s)
        else $error("soft reset did not restore defaults");
    a_gate_dc_inactive: assert property (!gate_live_q |=> !ctrl_q.outputs_enable && !ctrl_q.align_pin_o)
        else $error("outputs active while gated");
    a_gate_waits_vd: assert property ($rose(gate_live_q) |-> $past(vd_rise))
        else $error("outputs enabled away from vertical edge");
    a_pin_direction: assert property (1'b1 |=> ctrl_q.align_pin_oe == !$past(regs_q.align_cfg[ALIGN_EN_BIT]))
        else $error("alignment pin direction wrong");
    a_pin_general_out: assert property ((gate_live_q && !regs_q.align_cfg[ALIGN_EN_BIT]
        && regs_q.align_cfg[ALIGN_SEL_MSB:ALIGN_SEL_LSB] == SEL_GENERAL_OUT)
        |=> ctrl_q.align_pin_o == $past(gpo_live_q))
        else $error("general bit not on alignment pin");
    a_suspend_follow: assert property (ctrl_q.clock_suspend |-> ctrl_q.align_pulse_active
        && $past(regs_q.align_clock_suspend_bit))
        else $error("clock suspend without active pulse");
    a_core_held_reset: assert property (!regs_q.timing_core_reset_n |=> !ctrl_q.core_reset_n)
        else $error("core released while reset bit low");
    a_osc_powered_down: assert property (!regs_q.oscillator_reset_bit |=> !ctrl_q.oscillator_enable)
        else $error("oscillator running while reset bit low");
    a_update_on_line: assert property ((hd_rise && line_cnt_q == line_live_q && !regs_q.update_freeze_bit)
        |=> ctrl_q.frame_update_strobe)
        else $error("no update strobe on selected line");
    a_freeze_blocks: assert property ((regs_q.update_freeze_bit && !ctrl_q.soft_reset_pulse) |=> !ctrl_q.frame_update_strobe
        && $stable(gate_live_q) && $stable(line_live_q))
        else $error("frame update while frozen");
    a_gpo_at_vd: assert property ($changed(gpo_live_q) |-> $past(vd_rise) || $past(ctrl_q.soft_reset_pulse))
        else $error("general bit changed away from vertical edge");
    a_serial_immediate: assert property ((wr_fire && wr_idx == IDX_ALIGN_POL && !$past(ctrl_q.soft_reset_pulse)
        && !ctrl_q.soft_reset_pulse) |=> regs_q.align_polarity_bit == $past(wr_new[0]))
        else $error("serial-clock register not applied at once");
endmodule : tgm_misc_regs

// ==== sim/tgm_pulse_model.sv ====
`timescale 1ns/10ps
module tgm_pulse_model
    import tgm_pkg::*;
#(
    parameter int LINE_CYCLES = 8,
    parameter int FRAME_LINES = 6
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [2:0] src_level,
    output tgm_pulses_t pulses
);
    int cyc_q;
    int line_q;
    // Free-running line and frame counters
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cyc_q <= 0;
            line_q <= 0;
        end
        else
        begin
            cyc_q <= (cyc_q == LINE_CYCLES - 1) ? 0 : cyc_q + 1;
            if (cyc_q == LINE_CYCLES - 1)
                line_q <= (line_q == FRAME_LINES - 1) ? 0 : line_q + 1;
        end
    end
    // Vertical edge kept two cycles off the horizontal edge
    assign pulses.horizontal_drive_pulse = aresetn && (cyc_q == 0);
    assign pulses.vertical_drive_pulse = aresetn && (line_q == 0) && (cyc_q == 2);
    assign pulses.black_clamp_pulse = src_level[2];
    assign pulses.pre_blank_pulse = src_level[1];
    assign pulses.shutter_test_output = src_level[0];
endmodule : tgm_pulse_model

// ==== sim/tb.sv ====
`timescale 1ns/10ps
module tb
    import tgm_pkg::*;
;
    typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e; logic [1:0] r;} tgm_row_t;
    logic aclk = 1'b0;
    logic aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rs;
    logic [2:0] src_level;
    logic align_ext, pin_wire, vd_prev, hd_prev;
    int error_cnt, total_checks, hd_cnt, strobe_n, strobe_at, srst_n;
    tgm_pulses_t pulses;
    tgm_ctrl_t ctrl;
    tgm_row_t rows [13] = '{
        '{8'h4C, 32'h1, 32'h1, RESP_OKAY}, '{8'h50, 32'h1, 32'h1, RESP_OKAY},
        '{8'h54, 32'h1, 32'h1, RESP_OKAY}, '{8'h58, 32'h1, 32'h1, RESP_OKAY},
        '{8'h5C, 32'h0, 32'h0, RESP_OKAY}, '{8'h60, 32'hFFFFFABC, 32'hABC, RESP_OKAY},
        '{8'h48, 32'h301, 32'h301, RESP_OKAY}, '{8'h64, 32'h1, 32'h1, RESP_OKAY},
        '{8'h68, 32'hFFFFFFFF, 32'h1, RESP_OKAY}, '{8'h44, 32'h1, 32'h1, RESP_OKAY},
        '{8'h40, 32'h0, 32'h0, RESP_OKAY}, '{8'h6C, 32'h5, 32'h0, RESP_DECERR},
        '{8'h00, 32'h5, 32'h0, RESP_DECERR}
    };

    always #2.5 aclk = ~aclk;
    assign pin_wire = ctrl.align_pin_oe ? ctrl.align_pin_o : align_ext;

    tgm_pulse_model u_model (.aclk(aclk), .aresetn(aresetn), .src_level(src_level), .pulses(pulses));
    tgm_misc_regs u_dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pulses(pulses),
        .align_pin_i(pin_wire), .ctrl(ctrl));

    // Horizontal edges since the last vertical edge, logged at each update strobe
    always @(negedge aclk)
    begin
        if (pulses.vertical_drive_pulse && !vd_prev)
            hd_cnt = 0;
        if (pulses.horizontal_drive_pulse && !hd_prev)
            hd_cnt++;
        if (ctrl.soft_reset_pulse === 1'b1)
            srst_n++;
        if (ctrl.frame_update_strobe === 1'b1)
        begin
            strobe_n++;
            strobe_at = hd_cnt;
        end
        vd_prev = pulses.vertical_drive_pulse;
        hd_prev = pulses.horizontal_drive_pulse;
    end

    task automatic test_done();
        if (error_cnt == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : test_done

    task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_data

    task automatic chk_bit(input logic got, input logic exp);
        total_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_bit

    // Ready and valid are sampled mid-cycle; both stay put through the next rising edge
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_hs, w_hs, b_hs;
        int n;
        n = 0;
        b_hs = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!b_hs && n < 100)
        begin
            @(negedge aclk);
            aw_hs = awvalid && awready;
            w_hs = wvalid && wready;
            b_hs = bvalid && bready;
            r = bresp;
            @(posedge aclk);
            if (aw_hs)
                awvalid <= 1'b0;
            if (w_hs)
                wvalid <= 1'b0;
            n++;
        end
        if (!b_hs)
            error_cnt++;
        bready <= 1'b0;
    endtask : axi_write

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ar_hs, r_hs;
        int n;
        n = 0;
        r_hs = 1'b0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!r_hs && n < 100)
        begin
            @(negedge aclk);
            ar_hs = arvalid && arready;
            r_hs = rvalid && rready;
            d = rdata;
            r = rresp;
            @(posedge aclk);
            if (ar_hs)
                arvalid <= 1'b0;
            n++;
        end
        if (!r_hs)
            error_cnt++;
        rready <= 1'b0;
    endtask : axi_read

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        axi_write(a, d, r);
        repeat (3) @(negedge aclk);
    endtask : wr

    task automatic wait_vd();
        logic prev;
        int n;
        n = 0;
        prev = 1'b1;
        @(negedge aclk);
        while (!(pulses.vertical_drive_pulse && !prev) && n < 200)
        begin
            prev = pulses.vertical_drive_pulse;
            @(negedge aclk);
            n++;
        end
        if (!(pulses.vertical_drive_pulse && !prev))
            error_cnt++;
        repeat (4) @(negedge aclk);
    endtask : wait_vd

    task automatic chk_defaults();
        for (int i = 0; i < 11; i++)
        begin
            axi_read(8'h40 + 8'(4 * i), rd, rs);
            chk_data(rd, (i == 2) ? 32'h1 : 32'h0);
            chk_data(32'(rs), 32'(RESP_OKAY));
        end
    endtask : chk_defaults

    initial
    begin
        repeat (20000) @(posedge aclk);
        error_cnt++;
        test_done();
    end

    initial
    begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, align_ext} = 7'h00;
        {awaddr, araddr, wdata, wstrb, src_level} = 55'h0;
        {error_cnt, total_checks, hd_cnt, strobe_n, strobe_at, srst_n} = '0;
        {vd_prev, hd_prev} = 2'h0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (4) @(negedge aclk);
        chk_bit(ctrl.outputs_enable, 1'b0);
        chk_bit(ctrl.core_reset_n, 1'b0);
        chk_bit(ctrl.oscillator_enable, 1'b0);
        chk_bit(ctrl.align_pin_oe, 1'b0);
        chk_defaults();
        foreach (rows[i])
        begin
            axi_write(rows[i].a, rows[i].d, rs);
            chk_data(32'(rs), 32'(rows[i].r));
            axi_read(rows[i].a, rd, rs);
            chk_data(rd, rows[i].e);
            chk_data(32'(rs), 32'(rows[i].r));
        end
        repeat (3) @(negedge aclk);
        chk_bit(ctrl.core_reset_n, 1'b1);
        chk_bit(ctrl.oscillator_enable, 1'b1);
        chk_bit(ctrl.align_pulse_active, 1'b0);
        @(posedge aclk);
        align_ext <= 1'b1;
        repeat (8) @(negedge aclk);
        chk_bit(ctrl.align_pulse_active, 1'b1);
        chk_bit(ctrl.clock_suspend, 1'b1);
        wr(8'h4C, 32'h0);
        chk_bit(ctrl.align_pulse_active, 1'b0);
        chk_bit(ctrl.clock_suspend, 1'b0);
        wr(8'h50, 32'h0);
        wr(8'h4C, 32'h1);
        chk_bit(ctrl.align_pulse_active, 1'b1);
        chk_bit(ctrl.clock_suspend, 1'b0);
        wr(8'h40, 32'h1);
        chk_data(32'(srst_n), 32'h1);
        chk_bit(ctrl.core_reset_n, 1'b0);
        chk_bit(ctrl.oscillator_enable, 1'b0);
        chk_defaults();
        wait_vd();
        wr(8'h44, 32'h1);
        chk_bit(ctrl.outputs_enable, 1'b0);
        wait_vd();
        chk_bit(ctrl.outputs_enable, 1'b1);
        wr(8'h68, 32'h1);
        wait_vd();
        for (int s = 0; s < 4; s++)
            for (int v = 0; v < 2; v++)
            begin
                wr(8'h48, 32'(s) << 8);
                @(posedge aclk);
                src_level <= {3{v[0]}};
                repeat (4) @(negedge aclk);
                chk_bit(ctrl.align_pin_oe, 1'b1);
                chk_bit(pin_wire, (s == 2) ? 1'b1 : v[0]);
            end
        wr(8'h48, 32'h200);
        wait_vd();
        wr(8'h68, 32'h0);
        chk_bit(pin_wire, 1'b1);
        wait_vd();
        chk_bit(pin_wire, 1'b0);
        wr(8'h64, 32'h1);
        wr(8'h68, 32'h1);
        strobe_n = 0;
        wait_vd();
        wait_vd();
        chk_bit(pin_wire, 1'b0);
        chk_data(32'(strobe_n), 32'h0);
        wr(8'h64, 32'h0);
        wait_vd();
        chk_bit(pin_wire, 1'b1);
        wr(8'h60, 32'h3);
        wait_vd();
        wait_vd();
        strobe_n = 0;
        wait_vd();
        chk_data(32'(strobe_n), 32'h1);
        chk_data(32'(strobe_at), 32'h4);
        // Mid-run reset returns the gate, core reset, oscillator and pin-direction controls to their defaults
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (4) @(negedge aclk);
        chk_bit(ctrl.outputs_enable, 1'b0);
        chk_bit(ctrl.core_reset_n, 1'b0);
        chk_bit(ctrl.oscillator_enable, 1'b0);
        chk_bit(ctrl.align_pin_oe, 1'b0);
        chk_defaults();
        test_done();
    end
endmodule : tb
